// ===== shared/cgo_pkg.sv
// Purpose: types shared by the clamp control and its serial port
// Assumes: nothing beyond SystemVerilog packed types
// Notes: register offsets, field positions and reset values live in cgo_regs.svh
package cgo_pkg;

    // ------------------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {CL_IDLE, CL_WAIT, CL_ON} cgo_clamp_e;
    typedef enum logic [3:0] {
        SR_IDLE, SR_ADDR, SR_ACK_A, SR_REG, SR_ACK_R, SR_WR, SR_ACK_W, SR_RD, SR_MACK
    } cgo_ser_e;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {logic [7:0] r; logic [7:0] g; logic [7:0] b;} cgo_rgb8_s;
    typedef struct packed {logic [6:0] r; logic [6:0] g; logic [6:0] b;} cgo_rgb7_s;
    typedef struct packed {
        logic signed [6:0] r;
        logic signed [6:0] g;
        logic signed [6:0] b;
    } cgo_off_s;
    typedef struct packed {logic stb; logic [7:0] addr; logic [7:0] data;} cgo_wr_s;

    // settings that take effect per line
    typedef struct packed {
        cgo_rgb8_s gain;
        cgo_rgb7_s off;
        logic [2:0] tgt;
        logic [7:0] place;
        logic [7:0] dur;
    } cgo_line_s;

    // ------------------------------------------------------------------------
    // module state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        cgo_ser_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic nack;
        logic oe;
        cgo_wr_s wr;
    } cgo_ser_s;

    typedef struct packed {
        logic [2:0] hs_s;
        logic [2:0] ck_s;
        logic [2:0] sg_s;
        logic hs_f;
        logic ck_f;
        logic sg_f;
        cgo_line_s regs;
        cgo_line_s sh;
        logic [7:0] sog;
        logic ext;
        logic pol;
        cgo_clamp_e st;
        logic [7:0] cnt;
        logic clamp;
        cgo_rgb8_s code;
        cgo_off_s offl;
        logic sog_hs;
        logic [7:0] since;
        logic [7:0] len;
    } cgo_ctl_s;

endpackage

// ===== shared/cgo_regs.svh
// Purpose: register offsets, field positions and reset values of the clamp control
// Assumes: 8-bit sub-address space on the serial control port
// Notes: definitions only
`ifndef CGO_REGS_SVH
`define CGO_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CGO_A_TGT 8'h0F
`define CGO_A_SOG 8'h11
`define CGO_A_GAIN_R 8'h20
`define CGO_A_GAIN_G 8'h21
`define CGO_A_GAIN_B 8'h22
`define CGO_A_OFF_R 8'h23
`define CGO_A_OFF_G 8'h24
`define CGO_A_OFF_B 8'h25
`define CGO_A_PLACE 8'h26
`define CGO_A_DUR 8'h27
`define CGO_A_CTL 8'h28
`define CGO_A_STAT 8'h29

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define CGO_CTL_EXT 0
`define CGO_CTL_POL 1
`define CGO_STAT_CLAMP 0
`define CGO_STAT_HSYNC 1
`define CGO_STAT_WAIT 2

// ----------------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------------
`define CGO_TGT_RST 3'h0
`define CGO_SOG_RST 8'h80
`define CGO_GAIN_RST 8'h80
`define CGO_OFF_RST 7'h40
`define CGO_PLACE_RST 8'h08
`define CGO_DUR_RST 8'h14
`define CGO_POL_RST 1'b1
`define CGO_CODE_MID 8'h80
`define CGO_CODE_GND 8'h00
`define CGO_OFF_ZERO 7'h40
`define CGO_OFF_MIN 7'h41

`endif

// ===== tb/cgo_src_model.sv
// Purpose: graphics source model driving hsync, clamp pin and green sync
// Assumes: one hsync pulse per line request, active high, six clocks wide
// Notes: clamp pin and green sync follow levels set by the bench
`timescale 1ns/1ps

module cgo_src_model (
    input wire logic clock_i,
    input wire logic line_i,
    input wire logic clamp_lvl_i,
    input wire logic green_lvl_i,
    output logic hsync_o,
    output logic clamp_pin_o,
    output logic green_o
);
    // ------------------------------------------------------------------------
    // hsync pulse
    // ------------------------------------------------------------------------
    logic [3:0] hs_cnt_q = 4'h0;

    // pulse wide enough to pass the three-stage input filter
    always_ff @(posedge clock_i) begin
        if (line_i) begin
            hs_cnt_q <= 4'h6;
        end else if (hs_cnt_q != 4'h0) begin
            hs_cnt_q <= hs_cnt_q - 4'h1;
        end
    end

    // levels driven straight, the source has no idle state on these pins
    assign hsync_o = (hs_cnt_q != 4'h0);
    assign clamp_pin_o = clamp_lvl_i;
    assign green_o = green_lvl_i;
endmodule // cgo_src_model

// ===== tb/tb_clamp_gain_offset_control.sv
// Purpose: self-checking bench of the clamp, gain, offset and sync-on-green control
// Assumes: serial bit phases of four to eight clocks, well above the filter delay
// Notes: expectations come from register values written by the bench
`timescale 1ns/1ps
`include "cgo_regs.svh"

module tb_clamp_gain_offset_control;
    import cgo_pkg::*;
    localparam logic [6:0] DEV = 7'h4C; // arbitrary value
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic scl = 1'b1;
    logic sda_low = 1'b0;
    logic line_go = 1'b0;
    logic clamp_lvl = 1'b0;
    logic green_lvl = 1'b0;
    logic hsync, clamp_pin, green, sda_o, sda_oe_o, clamp_o, sog_hsync_o;
    cgo_rgb8_s clamp_code_o, gain_o;
    cgo_rgb7_s offset_o;
    cgo_off_s offset_lsb_o;
    logic [7:0] sog_level_o;
    int failures = 0;
    int n_checks = 0;
    int r1, w1, r2, w2;
    logic [7:0] rv;
    // open-drain data line with pull-up
    wire sda = ~(sda_oe_o | sda_low);

    always #2.5 clock_i = ~clock_i;

    cgo_src_model src_u (.clock_i(clock_i), .line_i(line_go), .clamp_lvl_i(clamp_lvl),
        .green_lvl_i(green_lvl), .hsync_o(hsync), .clamp_pin_o(clamp_pin), .green_o(green));

    cgo_clamp_ctrl #(.DEV_ADDR(DEV)) dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .hsync_i(hsync),
        .clamp_pin_i(clamp_pin), .green_sync_input_i(green), .clamp_o(clamp_o),
        .clamp_code_o(clamp_code_o), .gain_o(gain_o), .offset_o(offset_o),
        .offset_lsb_o(offset_lsb_o), .sog_level_o(sog_level_o), .sog_hsync_o(sog_hsync_o));

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task complete_run();
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one byte out, then the slave's acknowledge sampled while scl is high
    task wr_byte(input logic [7:0] b);
        logic ack;
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~b[i];
            tick(4);
            scl = 1'b1;
            tick(8);
            scl = 1'b0;
            tick(4);
        end
        sda_low = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        ack = sda;
        tick(4);
        scl = 1'b0;
        tick(4);
        check({31'h0, ack}, 32'h0);
    endtask

    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        sda_low = 1'b1;
        tick(8);
        scl = 1'b0;
        tick(4);
        wr_byte({DEV, 1'b0});
        wr_byte(a);
        wr_byte(d);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_low = 1'b0;
        tick(8);
    endtask

    // pointer set by a sub-address write, then repeated start, one byte, master nack
    task reg_rd(input logic [7:0] a, output logic [7:0] v);
        sda_low = 1'b1;
        tick(8);
        scl = 1'b0;
        tick(4);
        wr_byte({DEV, 1'b0});
        wr_byte(a);
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_low = 1'b1;
        tick(8);
        scl = 1'b0;
        tick(4);
        wr_byte({DEV, 1'b1});
        for (int i = 0; i < 9; i++) begin
            tick(4);
            scl = 1'b1;
            tick(4);
            v = (i < 8) ? {v[6:0], sda} : v;
            tick(4);
            scl = 1'b0;
            tick(4);
        end
        sda_low = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(8);
        sda_low = 1'b0;
        tick(8);
    endtask

    // one line: clock count to clamp start and clamp width, both bounded
    task run_line(output int rise, output int width);
        line_go = 1'b1;
        tick(1);
        line_go = 1'b0;
        rise = 0;
        width = 0;
        while (clamp_o !== 1'b1 && rise < 400) begin
            tick(1);
            rise++;
        end
        while (clamp_o === 1'b1 && width < 400) begin
            tick(1);
            width++;
        end
        if (rise >= 400 || width >= 400) begin
            failures++;
            complete_run();
        end
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task sc_internal_clamp();
        run_line(r1, w1);
        check(w1, 32'h14);
        reg_wr(`CGO_A_PLACE, 8'h02);
        reg_wr(`CGO_A_DUR, 8'h03);
        run_line(r2, w2);
        check(w2, 32'h3);
        check(r1 - r2, 32'h6);
    endtask

    // edge while waiting restarts placement; edge while clamping is ignored
    task sc_restart();
        reg_wr(`CGO_A_PLACE, 8'h20);
        reg_wr(`CGO_A_DUR, 8'h03);
        line_go = 1'b1;
        tick(1);
        line_go = 1'b0;
        tick(12);
        run_line(r1, w1);
        check(r1, 32'h2A);
        check(w1, 32'h3);
        reg_wr(`CGO_A_PLACE, 8'h00);
        reg_wr(`CGO_A_DUR, 8'h30);
        line_go = 1'b1;
        tick(1);
        line_go = 1'b0;
        tick(14);
        run_line(r2, w2);
        check(r2, 32'h0);
        check(w2, 32'h2B);
        reg_wr(`CGO_A_PLACE, 8'h08);
        reg_wr(`CGO_A_DUR, 8'h14);
    endtask

    // settings written mid-line must wait for the next hsync trailing edge
    task sc_settings();
        reg_wr(`CGO_A_TGT, 8'h05);
        reg_wr(`CGO_A_GAIN_R, 8'h00);
        reg_wr(`CGO_A_GAIN_G, 8'hFF);
        reg_wr(`CGO_A_OFF_R, 8'h00);
        reg_wr(`CGO_A_OFF_G, 8'h7F);
        check(gain_o, 32'h808080);
        run_line(r1, w1);
        check(clamp_code_o, {8'h80, 8'h00, 8'h80});
        check(gain_o, {8'h00, 8'hFF, 8'h80});
        check(offset_o, {7'h00, 7'h7F, 7'h40});
        check(offset_lsb_o, {7'h41, 7'h3F, 7'h00});
    endtask

    task sc_external();
        reg_wr(`CGO_A_CTL, 8'h03);
        clamp_lvl = 1'b1;
        tick(8);
        check(clamp_o, 32'h1);
        clamp_lvl = 1'b0;
        tick(8);
        check(clamp_o, 32'h0);
        reg_wr(`CGO_A_CTL, 8'h01);
        tick(8);
        check(clamp_o, 32'h1);
        clamp_lvl = 1'b1;
        tick(8);
        check(clamp_o, 32'h0);
    endtask

    task sc_green_sync();
        green_lvl = 1'b1;
        tick(8);
        check(sog_hsync_o, 32'h0);
        green_lvl = 1'b0;
        tick(8);
        check(sog_hsync_o, 32'h1);
        reg_wr(`CGO_A_SOG, 8'h33);
        tick(2);
        check(sog_level_o, 32'h33);
        reg_rd(`CGO_A_SOG, rv);
        check(rv, 32'h33);
        reg_rd(`CGO_A_CTL, rv);
        check(rv, 32'h01);
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        tick(8);
        reset_n_i = 1'b1;
        tick(4);
        check(gain_o, 32'h808080);
        check(offset_o, {7'h40, 7'h40, 7'h40});
        check(sog_level_o, 32'h80);
        sc_internal_clamp();
        sc_restart();
        sc_settings();
        sc_external();
        sc_green_sync();
        complete_run();
    end
endmodule // tb_clamp_gain_offset_control

// ===== verilog/cgo_clamp_ctrl.sv
// Purpose: clamp timing, clamp target, gain, offset and sync-on-green level control
// Assumes: clock_i is the pixel clock; hsync_i is active high
// Notes: settings for the next line are captured at a trailing edge of hsync that comes while no clamp is running
`timescale 1ns/1ps
`include "cgo_regs.svh"

// Behaviour
// RULE1 - external clamp select set: clamp output follows the clamp pin
// RULE2 - clamp polarity bit decides whether the clamp pin is active high or low
// RULE3 - internal clamp starts a programmed pixel count after hsync trailing edge
// RULE4 - internal clamp lasts programmed pixel count; placement and duration are 8-bit
// RULE5 - software should program placement 0x08 and duration 0x14
// RULE6 - bits 0 to 2 of clamp_target_select select each converter's clamp target
// RULE7 - midscale target gives code 0x80, ground target gives code 0x00
// RULE8 - separate 8-bit gain per red, green and blue channel
// RULE9 - gain code 0 smallest input range, 255 largest range
// RULE10 - separate 7-bit offset per red, green and blue channel
// RULE11 - offset spans plus or minus 63 LSBs, step follows full scale
// RULE12 - sync-on-green trigger level programmable through sync_on_green_threshold
// RULE13 - sync taken from green sync input is always negative polarity
// RULE14 - internal mode restarts placement count at each hsync trailing edge; the code ignores edges that come while the clamp is on
// RULE15 - new settings apply from next line, running clamp interval not cut
module cgo_clamp_ctrl
    import cgo_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h4C // arbitrary value
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic hsync_i,
    input wire logic clamp_pin_i,
    input wire logic green_sync_input_i,
    output logic clamp_o,
    output cgo_rgb8_s clamp_code_o,
    output cgo_rgb8_s gain_o,
    output cgo_rgb7_s offset_o,
    output cgo_off_s offset_lsb_o,
    output logic [7:0] sog_level_o,
    output logic sog_hsync_o
);

    cgo_ctl_s q, d;
    cgo_wr_s wr;
    logic [7:0] rd_data;
    logic trail, take;

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    function automatic cgo_line_s line_rst();
        cgo_line_s l;
        l.gain = '{`CGO_GAIN_RST, `CGO_GAIN_RST, `CGO_GAIN_RST};
        l.off = '{`CGO_OFF_RST, `CGO_OFF_RST, `CGO_OFF_RST};
        l.tgt = `CGO_TGT_RST;
        l.place = `CGO_PLACE_RST; // RULE5
        l.dur = `CGO_DUR_RST; // RULE5
        return l;
    endfunction

    // glitch filter behind the three-stage synchroniser
    function automatic logic filt(input logic [2:0] s, input logic f);
        return (s[1] == s[2]) ? s[2] : f;
    endfunction

    function automatic logic [7:0] tgt_code(input logic mid);
        return mid ? `CGO_CODE_MID : `CGO_CODE_GND; // RULE7
    endfunction

    // code 0x40 is zero shift; code 0 would be -64, so it is held at -63
    function automatic logic signed [6:0] off_lsb(input logic [6:0] c);
        return (c == 7'h00) ? $signed(`CGO_OFF_MIN) : $signed(c ^ `CGO_OFF_ZERO); // RULE11
    endfunction

    function automatic logic [7:0] rd_mux(input cgo_ctl_s s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `CGO_A_TGT: v = {5'h00, s.regs.tgt};
            `CGO_A_SOG: v = s.sog;
            `CGO_A_GAIN_R: v = s.regs.gain.r;
            `CGO_A_GAIN_G: v = s.regs.gain.g;
            `CGO_A_GAIN_B: v = s.regs.gain.b;
            `CGO_A_OFF_R: v = {1'b0, s.regs.off.r};
            `CGO_A_OFF_G: v = {1'b0, s.regs.off.g};
            `CGO_A_OFF_B: v = {1'b0, s.regs.off.b};
            `CGO_A_PLACE: v = s.regs.place;
            `CGO_A_DUR: v = s.regs.dur;
            `CGO_A_CTL: begin
                v[`CGO_CTL_EXT] = s.ext;
                v[`CGO_CTL_POL] = s.pol;
            end
            `CGO_A_STAT: begin
                v[`CGO_STAT_CLAMP] = s.clamp;
                v[`CGO_STAT_HSYNC] = s.hs_f;
                v[`CGO_STAT_WAIT] = (s.st == CL_WAIT);
            end
            default: v = 8'h00; // unmapped reads as zero
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------------
    // serial register port
    // ------------------------------------------------------------------------
    cgo_ser_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_ser (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .rd_data_i(rd_data),
        .wr_o(wr),
        .sda_oe_o(sda_oe_o)
    );

    assign rd_data = rd_mux(q, wr.addr);

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        d.hs_s = {q.hs_s[1:0], hsync_i};
        d.ck_s = {q.ck_s[1:0], clamp_pin_i};
        d.sg_s = {q.sg_s[1:0], green_sync_input_i};
        d.hs_f = filt(q.hs_s, q.hs_f);
        d.ck_f = filt(q.ck_s, q.ck_f);
        d.sg_f = filt(q.sg_s, q.sg_f);
        // per-line settings land in the staging copy; threshold and control bits take effect at once
        if (wr.stb) begin
            case (wr.addr)
                `CGO_A_TGT: d.regs.tgt = wr.data[2:0]; // RULE6
                `CGO_A_SOG: d.sog = wr.data; // RULE12
                `CGO_A_GAIN_R: d.regs.gain.r = wr.data; // RULE8 RULE9
                `CGO_A_GAIN_G: d.regs.gain.g = wr.data; // RULE8
                `CGO_A_GAIN_B: d.regs.gain.b = wr.data; // RULE8
                `CGO_A_OFF_R: d.regs.off.r = wr.data[6:0]; // RULE10
                `CGO_A_OFF_G: d.regs.off.g = wr.data[6:0]; // RULE10
                `CGO_A_OFF_B: d.regs.off.b = wr.data[6:0]; // RULE10
                `CGO_A_PLACE: d.regs.place = wr.data; // RULE4
                `CGO_A_DUR: d.regs.dur = wr.data; // RULE4
                `CGO_A_CTL: begin
                    d.ext = wr.data[`CGO_CTL_EXT]; // RULE1
                    d.pol = wr.data[`CGO_CTL_POL]; // RULE2
                end
                default: ;
            endcase
        end
        // an edge during a running clamp is ignored so the interval runs out whole
        trail = q.hs_f & ~d.hs_f;
        take = trail & (q.st != CL_ON); // RULE15
        d.since = (q.since == 8'hFF) ? q.since : q.since + 8'h01;
        if (take) begin
            d.sh = q.regs; // RULE15
            d.since = 8'h00;
        end
        // placement and duration countdown
        unique case (q.st)
            CL_IDLE: ;
            CL_WAIT: if (q.cnt == 8'h01) begin
                d.st = (q.sh.dur == 8'h00) ? CL_IDLE : CL_ON; // RULE3
                d.cnt = q.sh.dur;
            end else begin
                d.cnt = q.cnt - 8'h01;
            end
            CL_ON: if (q.cnt == 8'h01) begin
                d.st = CL_IDLE; // RULE4
            end else begin
                d.cnt = q.cnt - 8'h01;
            end
        endcase
        if (take && !q.ext) begin
            if (q.regs.place != 8'h00) begin
                d.st = CL_WAIT; // RULE14 RULE3
                d.cnt = q.regs.place;
            end else if (q.regs.dur != 8'h00) begin
                d.st = CL_ON;
                d.cnt = q.regs.dur;
            end else begin
                d.st = CL_IDLE;
            end
        end
        if (q.ext) begin
            d.st = CL_IDLE; // RULE1
        end
        d.clamp = q.ext ? (d.ck_f ~^ q.pol) : (d.st == CL_ON); // RULE1 RULE2 RULE14
        if (d.st == CL_ON) begin
            d.len = (q.st == CL_ON) ? q.len + 8'h01 : 8'h01;
        end
        d.code = '{tgt_code(d.sh.tgt[0]), tgt_code(d.sh.tgt[1]), tgt_code(d.sh.tgt[2])};
        d.offl = '{off_lsb(d.sh.off.r), off_lsb(d.sh.off.g), off_lsb(d.sh.off.b)};
        d.sog_hs = ~d.sg_f; // RULE13
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
            q.regs <= line_rst();
            q.sh <= line_rst();
            q.sog <= `CGO_SOG_RST;
            q.pol <= `CGO_POL_RST;
            q.sog_hs <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign sda_o = 1'b0; // open drain, only the enable toggles
    assign clamp_o = q.clamp;
    assign clamp_code_o = q.code;
    assign gain_o = q.sh.gain;
    assign offset_o = q.sh.off;
    assign offset_lsb_o = q.offl;
    assign sog_level_o = q.sog;
    assign sog_hsync_o = q.sog_hs;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_edge_taken;
        take && !q.ext;
    endsequence

    a_ext_clamp_pin: assert property (q.ext |=> clamp_o == (q.ck_f ~^ $past(q.pol))) // RULE1
        else $error("clamp output does not follow clamp pin");
    a_int_place_delay: assert property ($rose(q.st == CL_ON) && !q.ext |-> // RULE3
        q.since == q.sh.place) else $error("clamp start not at placement count");
    a_int_clamp_len: assert property ($fell(q.st == CL_ON) && !$past(q.ext) |-> // RULE4
        q.len == q.sh.dur) else $error("clamp length differs from duration");
    a_wait_restart: assert property (q.st == CL_WAIT ##0 s_edge_taken // RULE14
        ##0 q.regs.place != 8'h00 |=> q.st == CL_WAIT && q.cnt == $past(q.regs.place))
        else $error("placement count not restarted at hsync edge");
    a_clamp_not_cut: assert property (q.st == CL_ON && trail && !q.ext && q.cnt > 8'h01 // RULE15
        |=> q.st == CL_ON && q.cnt == $past(q.cnt) - 8'h01) else $error("clamp cut by edge");
    a_gain_line: assert property ($changed(gain_o) |-> $past(take)) // RULE15
        else $error("gain changed mid line");
    a_target_code: assert property (clamp_code_o.g == (q.sh.tgt[1] ? 8'h80 : 8'h00)) // RULE7
        else $error("clamp target code wrong");
    a_offset_range: assert property ($signed(offset_lsb_o.b) >= -7'sd63) // RULE11
        else $error("offset beyond -63 LSB");
    a_gain_write: assert property (wr.stb && wr.addr == `CGO_A_GAIN_R |=> // RULE8
        q.regs.gain.r == $past(wr.data)) else $error("gain write lost");
    a_sog_write: assert property (wr.stb && wr.addr == `CGO_A_SOG |=> // RULE12
        sog_level_o == $past(wr.data)) else $error("threshold write lost");
    a_sog_polarity: assert property ($rose(q.sg_f) |=> !sog_hsync_o) // RULE13
        else $error("green sync not negative");

endmodule // cgo_clamp_ctrl

// ===== verilog/cgo_ser_slave.sv
// Purpose: two-wire serial register port, byte writes and reads with auto-increment
// Assumes: bus edges far slower than clock_i; SCL and SDA arrive unsynchronised
// Notes: SDA is open drain, only the enable is driven
`timescale 1ns/1ps
`include "cgo_regs.svh"

module cgo_ser_slave
    import cgo_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h4C // arbitrary value
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] rd_data_i,
    output cgo_wr_s wr_o,
    output logic sda_oe_o
);

    cgo_ser_s q, d;
    logic scl_n, sda_n, rise, fall, start, stop;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        d.scl_s = {q.scl_s[1:0], scl_i};
        d.sda_s = {q.sda_s[1:0], sda_i};
        // a level counts once second and third stage agree
        scl_n = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
        sda_n = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
        d.scl_f = scl_n;
        d.sda_f = sda_n;
        rise = ~q.scl_f & scl_n;
        fall = q.scl_f & ~scl_n;
        start = q.scl_f & scl_n & q.sda_f & ~sda_n;
        stop = q.scl_f & scl_n & ~q.sda_f & sda_n;
        d.wr.stb = 1'b0;
        if (start) begin
            d.st = SR_ADDR;
            d.cnt = 4'h0;
            d.oe = 1'b0;
        end else if (stop) begin
            d.st = SR_IDLE;
            d.oe = 1'b0;
        end else if (rise) begin
            // master ack also moves the pointer so the next load sees it
            if (q.st == SR_MACK) begin
                d.nack = sda_n;
                if (!sda_n) begin
                    d.wr.addr = q.wr.addr + 8'h01;
                end
            end else if (q.st != SR_RD) begin
                d.sh = {q.sh[6:0], sda_n};
            end
            d.cnt = q.cnt + 4'h1;
        end else if (fall) begin
            // sda only changes while scl is low
            unique case (q.st)
                SR_IDLE: ;
                SR_ADDR: if (q.cnt == 4'h8) begin
                    if (q.sh[7:1] == DEV_ADDR) begin
                        d.st = SR_ACK_A;
                        d.oe = 1'b1;
                        d.rw = q.sh[0];
                    end else begin
                        d.st = SR_IDLE;
                    end
                end
                SR_ACK_A: begin
                    d.cnt = 4'h0;
                    if (q.rw) begin
                        d.st = SR_RD;
                        d.sh = rd_data_i;
                        d.oe = ~rd_data_i[7];
                    end else begin
                        d.st = SR_REG;
                        d.oe = 1'b0;
                    end
                end
                SR_REG: if (q.cnt == 4'h8) begin
                    d.wr.addr = q.sh;
                    d.st = SR_ACK_R;
                    d.oe = 1'b1;
                end
                SR_ACK_R, SR_ACK_W: begin
                    if (q.st == SR_ACK_W) begin
                        d.wr.addr = q.wr.addr + 8'h01;
                    end
                    d.st = SR_WR;
                    d.cnt = 4'h0;
                    d.oe = 1'b0;
                end
                SR_WR: if (q.cnt == 4'h8) begin
                    d.wr.stb = 1'b1;
                    d.wr.data = q.sh;
                    d.st = SR_ACK_W;
                    d.oe = 1'b1;
                end
                SR_RD: if (q.cnt == 4'h8) begin
                    d.oe = 1'b0;
                    d.st = SR_MACK;
                end else begin
                    d.sh = {q.sh[6:0], 1'b0};
                    d.oe = ~q.sh[6];
                end
                SR_MACK: if (q.nack) begin
                    d.st = SR_IDLE;
                end else begin
                    d.st = SR_RD;
                    d.cnt = 4'h0;
                    d.sh = rd_data_i;
                    d.oe = ~rd_data_i[7];
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '0;
            q.scl_s <= 3'h7; // idle bus is high
            q.sda_s <= 3'h7;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign wr_o = q.wr;
    assign sda_oe_o = q.oe;

endmodule // cgo_ser_slave
